// ===== design/digipot_cmd_decoder.sv
/*
 * Command decoder for a single-channel 1024-position digital
 * potentiometer: wiper register, control bits, shutdown, readback.
 * Assumes a host drives the serial pins and the analog ladder
 * consumes the tap selection and mode outputs.
 */
// Overview of operation
// - Command is frame bits 13..10; code zero changes no register, and frame 8001 hex turns the output off for the next frame.
// - Code 0001 loads data bits 9..0 into the wiper register.
// - Code 0010 sends the wiper setting out during the next frame.
// - Code 0100 reloads the wiper register with midscale.
// - Code 0110 copies data bits 2 and 1 into control bits.
// - Code 0111 sends the control bits out during the next frame.
// - Code 1000 enters shutdown if bit 0 is one, leaves it if zero.
// - Calibration disable bit: zero calibrated (default), one normal.
// - Write unlock bit: zero blocks wiper writes (default), one permits.
// - The 10-bit wiper setting selects one of 1024 taps.
// - Wiper-to-A falls and wiper-to-B rises as the code rises.
// - Locked wiper ignores writes but still takes midscale resets.
// - The wiper register starts at midscale after power-up.
// - Readback frame is 16 bits, low ten bits hold the register.
// - Rising hardware reset edge loads midscale and default control.
`timescale 1ns/1ps
`include "digipot_consts.svh"

module digipot_cmd_decoder
	import digipot_pkg::*;
(
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// Serial pins
	input  wire logic sclk,
	input  wire logic sync_n,
	input  wire logic din,
	input  wire logic reset_pin,
	output logic      serial_data_output,
	output logic      serial_data_output_oe,
	// Ladder side
	output wiper_type wiper_setting_register,
	output logic [9:0] tap_select,
	output logic [9:0] wa_steps,
	output logic      calibration_disable_bit,
	output logic      wiper_write_unlock_bit,
	output logic      shutdown_q
);
	logic      frame_done;
	frame_type rx_word;
	frame_type tx_word_q;
	logic      sdo_bit;
	logic      sdo_hiz_q;
	logic [2:0] rpin_s;
	logic [1:0] frame_sel_s;
	cmd_type   cmd;
	wiper_type data;

	assign cmd  = rx_word[`CMD_MSB:`CMD_LSB];
	assign data = rx_word[`DATA_MSB:`DATA_LSB];

	digipot_shifter u_shifter (
		.core_clk   (core_clk),
		.rst        (rst),
		.sclk       (sclk),
		.sync_n     (sync_n),
		.din        (din),
		.tx_word    (tx_word_q),
		.frame_done (frame_done),
		.rx_word    (rx_word),
		.sdo_bit    (sdo_bit)
	);

	// ****************************************
	// Hardware reset pin edge
	// ****************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rpin_s <= 3'h7;
		end else begin
			rpin_s <= {rpin_s[1:0], reset_pin};
		end
	end

	wire rpin_rise = ~rpin_s[2] & rpin_s[1];

	// ****************************************
	// Frame select for the pin driver
	// ****************************************
	// Raw select is asynchronous; never gate the driver with it directly
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			frame_sel_s <= 2'h3;
		end else begin
			frame_sel_s <= {frame_sel_s[0], sync_n};
		end
	end

	// ****************************************
	// Wiper register
	// ****************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wiper_setting_register <= `WIPER_MIDSCALE;
		end else if (rpin_rise) begin
			wiper_setting_register <= `WIPER_MIDSCALE;
		end else if (frame_done) begin
			if (cmd == `CMD_WIPER_WR && wiper_write_unlock_bit) begin
				wiper_setting_register <= data;
			end else if (cmd == `CMD_MIDSCALE) begin
				wiper_setting_register <= `WIPER_MIDSCALE;
			end
		end
	end

	// ****************************************
	// Control bits
	// ****************************************
	// Software midscale reset also restores control defaults
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			{calibration_disable_bit, wiper_write_unlock_bit} <= `CTRL_DEFAULT;
		end else if (rpin_rise) begin
			{calibration_disable_bit, wiper_write_unlock_bit} <= `CTRL_DEFAULT;
		end else if (frame_done) begin
			if (cmd == `CMD_CTRL_WR) begin
				calibration_disable_bit <= data[`CAL_DIS_POS];
				wiper_write_unlock_bit  <= data[`UNLOCK_POS];
			end else if (cmd == `CMD_MIDSCALE) begin
				{calibration_disable_bit, wiper_write_unlock_bit} <= `CTRL_DEFAULT;
			end
		end
	end

	// ****************************************
	// Shutdown
	// ****************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			shutdown_q <= 1'b0;
		end else if (frame_done && cmd == `CMD_SHUTDOWN) begin
			shutdown_q <= data[`SHDN_POS];
		end
	end

	// ****************************************
	// Readback word
	// ****************************************
	// Other frames echo the received word, as a daisy chain expects
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tx_word_q <= 16'h0000;
			sdo_hiz_q <= 1'b0;
		end else if (frame_done) begin
			sdo_hiz_q <= (rx_word == 16'h8001);
			if (cmd == `CMD_WIPER_RD) begin
				tx_word_q <= {6'h00, wiper_setting_register};
			end else if (cmd == `CMD_CTRL_RD) begin
				tx_word_q <= {13'h0000, calibration_disable_bit,
					wiper_write_unlock_bit, 1'b0};
			end else begin
				tx_word_q <= rx_word;
			end
		end
	end

	// ****************************************
	// Pin drivers and ladder decode
	// ****************************************
	// Open drain: drive only when sending a zero
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			serial_data_output    <= 1'b0;
			serial_data_output_oe <= 1'b0;
			tap_select            <= `WIPER_MIDSCALE;
			wa_steps              <= ~`WIPER_MIDSCALE;
		end else begin
			serial_data_output    <= 1'b0;
			serial_data_output_oe <= ~sdo_bit & ~sdo_hiz_q & ~frame_sel_s[1];
			tap_select            <= wiper_setting_register;
			wa_steps              <= ~wiper_setting_register;
		end
	end
endmodule

// ===== design/digipot_shifter.sv
/*
 * Serial shifter: samples the host clock, frame select and data input,
 * collects one 16-bit frame and shifts out a preloaded 16-bit word.
 * Assumes host pins are asynchronous to core_clk and much slower.
 */
`timescale 1ns/1ps
`include "digipot_consts.svh"

module digipot_shifter
	import digipot_pkg::*;
(
	// Clock and reset
	input  wire logic      core_clk,
	input  wire logic      rst,
	// Host pins
	input  wire logic      sclk,
	input  wire logic      sync_n,
	input  wire logic      din,
	// Frame side
	input  wire frame_type tx_word,
	output logic           frame_done,
	output frame_type      rx_word,
	output logic           sdo_bit
);
	logic [2:0] sclk_s;
	logic [2:0] sync_s;
	logic [1:0] din_s;
	frame_type  shift_q;
	frame_type  tx_q;
	logic [4:0] count_q;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			// Host clock idles high, so no false edge after reset
			sclk_s <= 3'h7;
			sync_s <= 3'h7;
			din_s  <= 2'h0;
		end else begin
			sclk_s <= {sclk_s[1:0], sclk};
			sync_s <= {sync_s[1:0], sync_n};
			din_s  <= {din_s[0], din};
		end
	end

	wire sclk_fall = sclk_s[2] & ~sclk_s[1];
	wire sclk_rise = ~sclk_s[2] & sclk_s[1];
	wire sync_low  = ~sync_s[1];
	wire sync_end  = ~sync_s[2] & sync_s[1];

	// ****************************************
	// Shifting
	// ****************************************
	// Data in taken on falling edge, data out advanced on rising edge
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			shift_q    <= 16'h0000;
			tx_q       <= 16'h0000;
			count_q    <= 5'h00;
			frame_done <= 1'b0;
			rx_word    <= 16'h0000;
			sdo_bit    <= 1'b0;
		end else begin
			frame_done <= 1'b0;
			if (!sync_low) begin
				count_q <= 5'h00;
				tx_q    <= tx_word;
				sdo_bit <= tx_word[15];
			end else begin
				if (sclk_fall) begin
					shift_q <= {shift_q[14:0], din_s[1]};
					count_q <= count_q + 5'h01;
				end
				if (sclk_rise && count_q != 5'h00) begin
					tx_q    <= {tx_q[14:0], 1'b0};
					sdo_bit <= tx_q[14];
				end
			end
			// Frames are dropped unless the 5-bit clock count, which wraps at 32, ends at 16
			if (sync_end && count_q == 5'(`FRAME_BITS)) begin
				frame_done <= 1'b1;
				rx_word    <= shift_q;
			end
		end
	end
endmodule

// ===== dv/digipot_assertions.sv
/* Port checks for the command decoder. Assumes the bind below and
   the package compiled first. */
`timescale 1ns/1ps
`include "digipot_consts.svh"

module digipot_checker
	import digipot_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       sync_n,
	input wire logic       reset_pin,
	input wire logic       serial_data_output,
	input wire logic       serial_data_output_oe,
	input wire wiper_type  wiper_setting_register,
	input wire logic [9:0] tap_select,
	input wire logic [9:0] wa_steps,
	input wire logic       calibration_disable_bit,
	input wire logic       wiper_write_unlock_bit,
	input wire logic       shutdown_q
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_tap_follows: assert property (tap_select == $past(wiper_setting_register))
		else $error("tap select does not follow wiper");
	a_wa_mirror: assert property ((tap_select + wa_steps) == 10'h3FF)
		else $error("A side steps not complementary");
	a_update_idle: assert property ($changed({wiper_setting_register,
		calibration_disable_bit, wiper_write_unlock_bit, shutdown_q}) |-> sync_n)
		else $error("register moved inside a frame");
	a_locked_write: assert property ($changed(wiper_setting_register)
		&& !$past(wiper_write_unlock_bit) |-> wiper_setting_register == `WIPER_MIDSCALE)
		else $error("locked wiper took a write");
	a_shdn_keeps: assert property ($changed(shutdown_q) |-> $stable(wiper_setting_register))
		else $error("shutdown altered wiper");
	a_ctrl_apart: assert property ($changed({calibration_disable_bit,
		wiper_write_unlock_bit}) |-> $stable(shutdown_q))
		else $error("control write altered shutdown");
	a_pin_reset: assert property ($rose(reset_pin) |-> ##[2:8]
		(wiper_setting_register == 10'h200 && !wiper_write_unlock_bit && !calibration_disable_bit))
		else $error("reset pin edge not applied");
	a_sdo_low: assert property (serial_data_output == 1'b0)
		else $error("open drain value not low");
	a_oe_framed: assert property (serial_data_output_oe |-> !$past(sync_n, 3))
		else $error("return line driven outside a frame");
endmodule

bind digipot_cmd_decoder digipot_checker ports_chk (.core_clk, .rst, .sync_n, .reset_pin,
	.serial_data_output, .serial_data_output_oe, .wiper_setting_register, .tap_select, .wa_steps,
	.calibration_disable_bit, .wiper_write_unlock_bit, .shutdown_q);

// ===== dv/digipot_host_model.sv
/* Host side of the serial link: shifts frames out MSB first and
   collects the returned word. Assumes a pulled-up return line. */
`timescale 1ns/1ps

module host_model
	import digipot_pkg::*;
(
	// Clock and return line
	input  wire logic core_clk,
	input  wire logic sdo_line,
	// Frame pins
	output logic      sclk,
	output logic      sync_n,
	output logic      din
);
	// Half period in core cycles; the bench may slow the host down
	int half = 6;

	initial begin
		sclk = 1'b1;
		sync_n = 1'b1;
		din = 1'b0;
	end

	// Fewer than 16 clocks gives a frame the device has to drop
	task automatic xfer(input frame_type f, input int n, output frame_type r);
		r = '0;
		@(posedge core_clk) #1 sync_n = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			din = f[i];
			repeat (half) @(posedge core_clk);
			#1 r = {r[14:0], sdo_line};
			sclk = 1'b0;
			repeat (half) @(posedge core_clk);
			#1 sclk = 1'b1;
		end
		repeat (half) @(posedge core_clk);
		#1 sync_n = 1'b1;
		din = ~din;
		repeat (10) @(posedge core_clk);
	endtask
endmodule

// ===== dv/digipot_serial_command_decoder_tb.sv
/* Self-checking bench for the command decoder: a frame table, then bad
   codes, short frames and both resets. Assumes the host model file. */
`timescale 1ns/1ps

module digipot_serial_command_decoder_tb
	import digipot_pkg::*;
;
	typedef struct packed {
		frame_type  frm;
		wiper_type  rx;
		wiper_type  wip;
		logic [2:0] ctl;
	} row_type;
	logic      core_clk, rst, reset_pin, sclk, sync_n, din, oe, cal, unl, shd;
	wiper_type wip, tap, wa;
	frame_type rx;
	int        err_total, samples_checked;
	cmd_type   bad [9] = '{4'h3, 4'h5, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
	// Return column: echo of the previous frame unless it was a read, or 8001 hex, which leaves the line pulled high
	row_type   rows [13] = '{'{16'h0500, 10'h000, 10'h200, 3'h0},
		'{16'h1802, 10'h100, 10'h200, 3'h2}, '{16'h0500, 10'h002, 10'h100, 3'h2},
		'{16'h0800, 10'h100, 10'h100, 3'h2}, '{16'h03FF, 10'h100, 10'h100, 3'h2},
		'{16'h07FF, 10'h3FF, 10'h3FF, 3'h2}, '{16'h1C00, 10'h3FF, 10'h3FF, 3'h2},
		'{16'h1806, 10'h002, 10'h3FF, 3'h6}, '{16'h2001, 10'h006, 10'h3FF, 3'h7},
		'{16'h2000, 10'h001, 10'h3FF, 3'h6}, '{16'h8001, 10'h000, 10'h3FF, 3'h6},
		'{16'h1000, 10'h3FF, 10'h200, 3'h0}, '{16'h0500, 10'h000, 10'h200, 3'h0}};

	digipot_cmd_decoder uut (.core_clk, .rst, .sclk, .sync_n, .din, .reset_pin,
		.serial_data_output(), .serial_data_output_oe(oe), .wiper_setting_register(wip),
		.tap_select(tap), .wa_steps(wa), .calibration_disable_bit(cal),
		.wiper_write_unlock_bit(unl), .shutdown_q(shd));
	// Pull-up on the open-drain return line
	host_model host (.core_clk, .sdo_line(!oe), .sclk, .sync_n, .din);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic step(input frame_type f, input int n, input wiper_type w,
		input logic [2:0] c);
		host.xfer(f, n, rx);
		chk(16'(wip), 16'(w));
		chk(16'({cal, unl, shd}), 16'(c));
		chk(16'(tap), 16'(w));
		chk(16'(wa), 16'(10'h3FF - w));
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ****
	// Main sequence
	// ****
	initial begin
		rst = 1'b1;
		reset_pin = 1'b0;
		err_total = 0;
		samples_checked = 0;
		repeat (12) @(posedge core_clk);
		#1 rst = 1'b0;
		chk(16'(wip), 16'h0200);
		repeat (3) @(posedge core_clk);
		foreach (rows[i]) begin
			step(rows[i].frm, 16, rows[i].wip, rows[i].ctl);
			if (i > 0) chk(16'(rx[9:0]), 16'(rows[i].rx));
		end
		// Unlocked and off midscale, so a misread code would show
		step(16'h1802, 16, 10'h200, 3'h2);
		step(16'h04AA, 16, 10'h0AA, 3'h2);
		foreach (bad[i]) step({2'b00, bad[i], 10'h155}, 16, 10'h0AA, 3'h2);
		step(16'h1000, 16, 10'h200, 3'h0);
		host.half = 9;
		step(16'h1802, 16, 10'h200, 3'h2);
		step(16'h0500, 15, 10'h200, 3'h2);
		step(16'h0500, 16, 10'h100, 3'h2);
		host.half = 6;
		@(posedge core_clk) #1 reset_pin = 1'b1;
		repeat (5) @(posedge core_clk);
		#1 reset_pin = 1'b0;
		repeat (8) @(posedge core_clk);
		chk(16'({wip, unl, cal}), {10'h200, 2'h0});
		step(16'h1802, 16, 10'h200, 3'h2);
		step(16'h07FF, 16, 10'h3FF, 3'h2);
		@(posedge core_clk) #1 rst = 1'b1;
		repeat (2) @(posedge core_clk);
		#1 rst = 1'b0;
		chk(16'({wip, unl}), {10'h200, 1'b0});
		give_verdict();
	end

	// Expected run is near 66 us; a hang stops well past that
	initial begin
		#200000;
		err_total++;
		give_verdict();
	end
endmodule

// ===== shared/digipot_consts.svh
/*
 * Constants for the digital potentiometer serial command decoder:
 * frame layout, command codes, control bit positions and reset values.
 * Assumes inclusion by bare name from the package and the modules.
 */
`ifndef DIGIPOT_CONSTS_SVH
`define DIGIPOT_CONSTS_SVH

// ****************************************
// Frame layout
// ****************************************
`define FRAME_BITS      16
`define CMD_MSB         13
`define CMD_LSB         10
`define DATA_MSB        9
`define DATA_LSB        0

// ****************************************
// Command codes
// ****************************************
`define CMD_NOP         4'h0
`define CMD_WIPER_WR    4'h1
`define CMD_WIPER_RD    4'h2
`define CMD_MIDSCALE    4'h4
`define CMD_CTRL_WR     4'h6
`define CMD_CTRL_RD     4'h7
`define CMD_SHUTDOWN    4'h8

// ****************************************
// Control bits and reset values
// ****************************************
`define CAL_DIS_POS     2
`define UNLOCK_POS      1
`define SHDN_POS        0
`define WIPER_MIDSCALE  10'h200
`define CTRL_DEFAULT    2'h0

`endif

// ===== shared/digipot_pkg.sv
/*
 * Types shared by the command decoder and its serial shifter.
 * Assumes the constants header is on the include path.
 */
`include "digipot_consts.svh"

package digipot_pkg;
	typedef logic [9:0]  wiper_type;
	typedef logic [15:0] frame_type;
	typedef logic [3:0]  cmd_type;
endpackage
